// ==== core/rpm_pin_mux.v ====
// reset-out pin control and interrupt / spi / memory pin function mux,
// with a classic wishbone register slave.
// assumes clk_i is the system clock; pad buffers sit outside and resolve
// each pin from its out / oe / input-enable signals.
//
// The implementer's own choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`include "rpm_regs.vh"

// Notes on behaviour
// - internal system reset always asserts the reset-out pin.
// - without internal reset, force_reset_out holds reset-out asserted.
// - otherwise show_interrupt makes reset-out mirror internal interrupt requests.
// - with none of those, reset-out is driven high (negated).
// - reset-out is active low; while low, external data-bus overrides allowed.
// - reset-out floats during phase-lock-loop test mode.
// - transfer_size_show_enable puts cpu_transfer_size on int pins 7 and 6.
// - processor_status_show_enable puts cpu_processor_status on int pins 5..2.
// - mirrored pins lose edge-port function in emulation; nothing emulates it.
// - external reset request is synchronised, except raw in low-power stop.
// - other pins use the synchroniser only when configured as digital io.
// - a pin's pull-up is off whenever that pin is an output; an open-drain int pin set as output keeps it while released high.
// - both serial-port pull-up enables reset to zero.
// - reset-out/clock-out/oe inputs and reset-in output only in boundary scan.
// - open-drain and pull-up are selected by configuration register bits.
// - external memory interface pins can be general-purpose io.
// - spi master drives sck and mosi, reads miso; slave the reverse.
// - reset-out carries interrupt show; board reset logic must allow for it.
module rpm_pin_mux #(
  parameter INT_W = 8,
  parameter EMI_W = 8
) (
  input  wire             clk_i,
  input  wire             sys_rst_i,
  // wishbone slave
  input  wire             wb_cyc_i,
  input  wire             wb_stb_i,
  input  wire             wb_we_i,
  input  wire [4:0]       wb_adr_i,
  input  wire [3:0]       wb_sel_i,
  input  wire [31:0]      wb_dat_i,
  output wire [31:0]      wb_dat_o,
  output wire             wb_ack_o,
  // chip state, same clock
  input  wire             int_sys_rst_i,
  input  wire             irq_pending_i,
  input  wire             pll_test_mode_i,
  input  wire             stop_mode_i,
  input  wire             emulation_mode_i,
  input  wire             bscan_active_i,
  input  wire [1:0]       cpu_transfer_size_i,
  input  wire [3:0]       cpu_processor_status_i,
  // reset-out pin
  output wire             reset_out_pin_o,
  output wire             reset_out_pin_oe_o,
  output wire             reset_out_pin_ie_o,
  output wire             data_bus_override_ok_o,
  // reset-in pin
  input  wire             ext_reset_req_n_i,
  input  wire             bscan_reset_pin_out_i,
  output wire             ext_reset_req_n_o,
  output wire             reset_in_pin_o,
  output wire             reset_in_pin_oe_o,
  // other scan-only input enables
  output wire             system_clock_out_ie_o,
  output wire             out_enable_pin_ie_o,
  // edge-port interrupt pins
  input  wire [INT_W-1:0] int_pin_i,
  output wire [INT_W-1:0] int_pin_o,
  output wire [INT_W-1:0] int_pin_oe_o,
  output wire [INT_W-1:0] int_pin_pu_o,
  input  wire [INT_W-1:0] eport_out_i,
  input  wire [INT_W-1:0] eport_oe_i,
  output wire [INT_W-1:0] eport_in_o,
  output wire [INT_W-1:0] eport_avail_o,
  // external memory interface pins
  input  wire [EMI_W-1:0] emi_pin_i,
  output wire [EMI_W-1:0] emi_pin_o,
  output wire [EMI_W-1:0] emi_pin_oe_o,
  input  wire [EMI_W-1:0] emi_func_out_i,
  input  wire [EMI_W-1:0] emi_func_oe_i,
  output wire [EMI_W-1:0] emi_func_in_o,
  // serial ports
  input  wire [1:0]       sci_rxd_oe_i,
  output wire [1:0]       sci_rxd_pu_o,
  // spi pins
  input  wire             spi_sck_i,
  input  wire             spi_mosi_i,
  input  wire             spi_miso_i,
  output wire             sck_pin_o,
  output wire             sck_pin_oe_o,
  output wire             mosi_pin_o,
  output wire             mosi_pin_oe_o,
  output wire             miso_pin_o,
  output wire             miso_pin_oe_o,
  input  wire             sck_pin_i,
  input  wire             mosi_pin_i,
  input  wire             miso_pin_i,
  output wire             spi_sck_in_o,
  output wire             spi_data_in_o
);

  // ============================================================
  // registers
  reg                rst_ctrl_reg;
  reg [`RPM_CC_W-1:0] chip_cfg_reg;
  reg [INT_W-1:0]    int_out_reg;
  reg [INT_W-1:0]    int_dir_reg;
  reg [INT_W-1:0]    int_sel_reg;
  reg [INT_W-1:0]    int_pu_reg;
  reg [INT_W-1:0]    int_od_reg;
  reg [EMI_W-1:0]    emi_out_reg;
  reg [EMI_W-1:0]    emi_dir_reg;
  reg                ack_reg;
  reg [31:0]         rdat_reg;
  reg [31:0]         rdat_next;
  reg                rst_out_n_reg;
  reg                rst_out_n_next;
  reg [1:0]          ext_rst_sync_reg;
  reg [INT_W-1:0]    int_s1_reg;
  reg [INT_W-1:0]    int_s2_reg;
  reg [EMI_W-1:0]    emi_s1_reg;
  reg [EMI_W-1:0]    emi_s2_reg;

  wire force_rst   = rst_ctrl_reg;
  wire show_int    = chip_cfg_reg[`RPM_CC_SHOW_INT];
  wire tsiz_en     = chip_cfg_reg[`RPM_CC_TSIZ_EN];
  wire pstat_en    = chip_cfg_reg[`RPM_CC_PSTAT_EN];
  wire spi_master  = chip_cfg_reg[`RPM_CC_SPI_MASTER];
  wire emi_gpio_en = chip_cfg_reg[`RPM_CC_EMI_GPIO];

  wire bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
  // writes land at the ack edge, where the master samples ack high;
  // the request edge only launches ack and the read word
  wire bus_wr  = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg;

  // ============================================================
  // wishbone register writes
  // byte lanes: lane 0 bits 7:0, lane 1 bits 15:8, lane 2 bits 23:16
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rst_ctrl_reg <= `RPM_RST_CTRL_RV;
      chip_cfg_reg <= `RPM_CHIP_CFG_RV;
      int_out_reg  <= `RPM_BYTE_RV;
      int_dir_reg  <= `RPM_BYTE_RV;
      int_sel_reg  <= `RPM_BYTE_RV;
      int_pu_reg   <= `RPM_BYTE_RV;
      int_od_reg   <= `RPM_BYTE_RV;
      emi_out_reg  <= `RPM_BYTE_RV;
      emi_dir_reg  <= `RPM_BYTE_RV;
    end else if (bus_wr) begin
      case (wb_adr_i)
        `RPM_OFF_RST_CTRL: begin
          if (wb_sel_i[0]) begin
            rst_ctrl_reg <= wb_dat_i[`RPM_RC_FORCE_BIT];
          end
        end
        `RPM_OFF_CHIP_CFG: begin
          if (wb_sel_i[0]) begin
            chip_cfg_reg <= wb_dat_i[`RPM_CC_W-1:0];
          end
        end
        `RPM_OFF_INT_GPIO: begin
          if (wb_sel_i[0]) begin
            int_out_reg <= wb_dat_i[`RPM_GPIO_OUT_LSB +: INT_W];
          end
          if (wb_sel_i[1]) begin
            int_dir_reg <= wb_dat_i[`RPM_GPIO_DIR_LSB +: INT_W];
          end
          if (wb_sel_i[2]) begin
            int_sel_reg <= wb_dat_i[`RPM_GPIO_SEL_LSB +: INT_W];
          end
        end
        `RPM_OFF_INT_PAD: begin
          if (wb_sel_i[0]) begin
            int_pu_reg <= wb_dat_i[`RPM_PAD_PU_LSB +: INT_W];
          end
          if (wb_sel_i[1]) begin
            int_od_reg <= wb_dat_i[`RPM_PAD_OD_LSB +: INT_W];
          end
        end
        `RPM_OFF_EMI_GPIO: begin
          if (wb_sel_i[0]) begin
            emi_out_reg <= wb_dat_i[`RPM_GPIO_OUT_LSB +: EMI_W];
          end
          if (wb_sel_i[1]) begin
            emi_dir_reg <= wb_dat_i[`RPM_GPIO_DIR_LSB +: EMI_W];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ============================================================
  // wishbone read mux; unmapped offsets read zero and still ack
  // the read word is captured in the request cycle and stands with ack
  always @* begin
    rdat_next = `RPM_WORD_RV;
    case (wb_adr_i)
      `RPM_OFF_RST_CTRL: rdat_next[`RPM_RC_FORCE_BIT] = rst_ctrl_reg;
      `RPM_OFF_CHIP_CFG: rdat_next[`RPM_CC_W-1:0] = chip_cfg_reg;
      `RPM_OFF_INT_GPIO: begin
        rdat_next[`RPM_GPIO_OUT_LSB +: INT_W] = int_out_reg;
        rdat_next[`RPM_GPIO_DIR_LSB +: INT_W] = int_dir_reg;
        rdat_next[`RPM_GPIO_SEL_LSB +: INT_W] = int_sel_reg;
      end
      `RPM_OFF_INT_PAD: begin
        rdat_next[`RPM_PAD_PU_LSB +: INT_W] = int_pu_reg;
        rdat_next[`RPM_PAD_OD_LSB +: INT_W] = int_od_reg;
      end
      `RPM_OFF_EMI_GPIO: begin
        rdat_next[`RPM_GPIO_OUT_LSB +: EMI_W] = emi_out_reg;
        rdat_next[`RPM_GPIO_DIR_LSB +: EMI_W] = emi_dir_reg;
      end
      `RPM_OFF_STATUS: begin
        rdat_next[`RPM_ST_INT_LSB +: INT_W] = int_s2_reg;
        rdat_next[`RPM_ST_EMI_LSB +: EMI_W] = emi_s2_reg;
        rdat_next[`RPM_ST_RESET_OUT_PIN_N] = rst_out_n_reg;
        rdat_next[`RPM_ST_EXTRST_N] = ext_reset_req_n_o;
        rdat_next[`RPM_ST_INTRST]   = int_sys_rst_i;
      end
      default: rdat_next = `RPM_WORD_RV;
    endcase
  end

  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ack_reg  <= 1'b0;
      rdat_reg <= `RPM_WORD_RV;
    end else begin
      ack_reg  <= bus_req;
      rdat_reg <= bus_req ? rdat_next : `RPM_WORD_RV;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;

  // ============================================================
  // reset-out priority chain
  // registered so a change of control bits never glitches the board reset
  always @* begin
    if (int_sys_rst_i) begin
      rst_out_n_next = 1'b0;
    end else if (force_rst) begin
      rst_out_n_next = 1'b0;
    end else if (show_int) begin
      rst_out_n_next = ~irq_pending_i;
    end else begin
      rst_out_n_next = 1'b1;
    end
  end

  // system reset also asserts the pin at once, without a clock edge
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rst_out_n_reg <= 1'b0;
    end else begin
      rst_out_n_reg <= rst_out_n_next;
    end
  end

  assign reset_out_pin_o        = rst_out_n_reg;
  assign reset_out_pin_oe_o     = ~pll_test_mode_i;
  assign data_bus_override_ok_o = ~rst_out_n_reg;

  // ============================================================
  // scan-only pad directions
  assign reset_out_pin_ie_o    = bscan_active_i;
  assign system_clock_out_ie_o = bscan_active_i;
  assign out_enable_pin_ie_o   = bscan_active_i;
  assign reset_in_pin_oe_o     = bscan_active_i;
  assign reset_in_pin_o        = bscan_reset_pin_out_i;

  // ============================================================
  // external reset request; in stop mode the clock may be halted, so
  // the raw pin bypasses the synchroniser to be able to wake the chip
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      // idle high: no false request right after reset
      ext_rst_sync_reg <= 2'b11;
    end else begin
      ext_rst_sync_reg <= {ext_rst_sync_reg[0], ext_reset_req_n_i};
    end
  end

  assign ext_reset_req_n_o = stop_mode_i ? ext_reset_req_n_i
                                         : ext_rst_sync_reg[1];

  // ============================================================
  // general-purpose pin synchronisers
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      int_s1_reg <= `RPM_BYTE_RV;
      int_s2_reg <= `RPM_BYTE_RV;
      emi_s1_reg <= `RPM_BYTE_RV;
      emi_s2_reg <= `RPM_BYTE_RV;
    end else begin
      int_s1_reg <= int_pin_i;
      int_s2_reg <= int_s1_reg;
      emi_s1_reg <= emi_pin_i;
      emi_s2_reg <= emi_s1_reg;
    end
  end

  // ============================================================
  // interrupt pins: show functions, gpio or edge port, per bit
  genvar gi;
  generate
    for (gi = 0; gi < INT_W; gi = gi + 1) begin : g_int
      wire is_tsiz  = (gi >= `RPM_TSIZ_LSB) && (gi < `RPM_TSIZ_LSB + 2);
      wire is_pstat = (gi >= `RPM_PSTAT_LSB) && (gi < `RPM_PSTAT_LSB + 4);
      wire show_t   = is_tsiz & tsiz_en;
      wire show_p   = is_pstat & pstat_en;
      wire shown    = show_t | show_p;
      wire gpio     = int_sel_reg[gi];
      wire drv_val;
      wire drv_en;
      wire od_cut;
      if (gi >= `RPM_TSIZ_LSB && gi < `RPM_TSIZ_LSB + 2) begin : g_t
        assign drv_val = show_t ? cpu_transfer_size_i[gi - `RPM_TSIZ_LSB]
                       : (gpio ? int_out_reg[gi] : eport_out_i[gi]);
      end else if (gi >= `RPM_PSTAT_LSB && gi < `RPM_PSTAT_LSB + 4)
      begin : g_p
        assign drv_val = show_p
                       ? cpu_processor_status_i[gi - `RPM_PSTAT_LSB]
                       : (gpio ? int_out_reg[gi] : eport_out_i[gi]);
      end else begin : g_n
        assign drv_val = gpio ? int_out_reg[gi] : eport_out_i[gi];
      end
      assign drv_en = shown | (gpio ? int_dir_reg[gi] : eport_oe_i[gi]);
      // open drain only pulls low; mirrored cpu signals stay push-pull
      assign od_cut = ~shown & int_od_reg[gi] & drv_val;
      assign int_pin_o[gi]    = drv_val;
      assign int_pin_oe_o[gi] = drv_en & ~od_cut;
      // a released open-drain pin keeps its pull-up so the line can rise
      assign int_pin_pu_o[gi] = int_pu_reg[gi] & ~int_pin_oe_o[gi];
      // edge port watches the raw pad; it filters edges itself
      assign eport_in_o[gi]   = (gpio | shown) ? 1'b1 : int_pin_i[gi];
      // lost in emulation too; no external stand-in exists
      // so the emulation flag needs no term of its own here
      assign eport_avail_o[gi] = ~shown & ~gpio;
    end
  endgenerate

  // ============================================================
  // external memory interface pins as gpio
  assign emi_pin_o     = emi_gpio_en ? emi_out_reg : emi_func_out_i;
  assign emi_pin_oe_o  = emi_gpio_en ? emi_dir_reg : emi_func_oe_i;
  assign emi_func_in_o = emi_gpio_en ? {EMI_W{1'b0}} : emi_pin_i;

  // ============================================================
  // serial-port pull-ups
  assign sci_rxd_pu_o[0] = chip_cfg_reg[`RPM_CC_SCI0_PU] & ~sci_rxd_oe_i[0];
  assign sci_rxd_pu_o[1] = chip_cfg_reg[`RPM_CC_SCI1_PU] & ~sci_rxd_oe_i[1];
  // both terms above drop the pull-up on an output pin

  // ============================================================
  // spi pin directions
  assign sck_pin_o     = spi_sck_i;
  assign mosi_pin_o    = spi_mosi_i;
  assign miso_pin_o    = spi_miso_i;
  assign sck_pin_oe_o  = spi_master;
  assign mosi_pin_oe_o = spi_master;
  assign miso_pin_oe_o = ~spi_master;
  assign spi_sck_in_o  = sck_pin_i;
  assign spi_data_in_o = spi_master ? miso_pin_i : mosi_pin_i;

endmodule // rpm_pin_mux

// ==== core/rpm_regs.vh ====
// register offsets, field positions and reset values for the reset-out
// and interrupt-pin function multiplexer.
// assumes a 32-bit classic wishbone slave with word-aligned byte addresses.
`ifndef RPM_REGS_VH
`define RPM_REGS_VH

// ============================================================
// register byte offsets
`define RPM_ADR_W          5
`define RPM_OFF_RST_CTRL   5'h00
`define RPM_OFF_CHIP_CFG   5'h04
`define RPM_OFF_INT_GPIO   5'h08
`define RPM_OFF_INT_PAD    5'h0C
`define RPM_OFF_EMI_GPIO   5'h10
`define RPM_OFF_STATUS     5'h14

// ============================================================
// reset control fields
`define RPM_RC_FORCE_BIT   0

// ============================================================
// chip configuration fields
`define RPM_CC_SHOW_INT    0
`define RPM_CC_TSIZ_EN     1
`define RPM_CC_PSTAT_EN    2
`define RPM_CC_SCI0_PU     3
`define RPM_CC_SCI1_PU     4
`define RPM_CC_SPI_MASTER  5
`define RPM_CC_EMI_GPIO    6
`define RPM_CC_W           7

// ============================================================
// field layout of the int pin and emi gpio registers
`define RPM_GPIO_OUT_LSB   0
`define RPM_GPIO_DIR_LSB   8
`define RPM_GPIO_SEL_LSB   16
`define RPM_PAD_PU_LSB     0
`define RPM_PAD_OD_LSB     8

// ============================================================
// status fields
`define RPM_ST_INT_LSB     0
`define RPM_ST_EMI_LSB     8
`define RPM_ST_RESET_OUT_PIN_N    16
`define RPM_ST_EXTRST_N    17
`define RPM_ST_INTRST      18

// ============================================================
// pin groups inside the int pin vector
`define RPM_TSIZ_LSB       6
`define RPM_PSTAT_LSB      2

// ============================================================
// reset values
`define RPM_RST_CTRL_RV    1'b0
`define RPM_CHIP_CFG_RV    7'h00
`define RPM_BYTE_RV        8'h00
`define RPM_WORD_RV        32'h0000_0000

`endif

// ==== bench/rpm_board.sv ====
// board-side model: reset request source and pad resolution for int and
// memory-interface pins. assumes one system clock shared with the bench.
`timescale 1ns/1ps
module rpm_board (
  input  wire logic       clk_i,
  input  wire logic       req_rst_i,
  input  wire logic [7:0] int_drv_i, int_oe_i, int_pu_i, emi_drv_i, emi_oe_i,
  output logic            rst_n_o,
  output logic [7:0]      int_line_o, emi_line_o
);
  // ==========================================================
  // pad resolution
  // a released line with no pull-up flips every cycle, so a stale value
  // can never pass for a fresh one
  logic [7:0] tog_reg = 8'h5A;
  always @(posedge clk_i) tog_reg <= ~tog_reg;
  assign int_line_o = (int_oe_i & int_drv_i) | (~int_oe_i & (int_pu_i | tog_reg));
  assign emi_line_o = (emi_oe_i & emi_drv_i) | (~emi_oe_i & tog_reg);
  assign rst_n_o    = ~req_rst_i;
endmodule // rpm_board

// ==== bench/rpm_pin_mux_assertions.sv ====
// concurrent checks on the ports of the reset-out and pin function mux.
// assumes it is bound onto rpm_pin_mux; one clock domain.
`timescale 1ns/1ps
module rpm_pin_mux_assertions #(
  parameter INT_W = 8,
  parameter EMI_W = 8
) (
  input wire logic clk_i, sys_rst_i, wb_cyc_i, wb_stb_i, wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic int_sys_rst_i, reset_out_pin_o, reset_out_pin_oe_o,
  input wire logic pll_test_mode_i, data_bus_override_ok_o, bscan_active_i,
  input wire logic reset_out_pin_ie_o, system_clock_out_ie_o,
  input wire logic out_enable_pin_ie_o, reset_in_pin_oe_o, stop_mode_i,
  input wire logic ext_reset_req_n_i, ext_reset_req_n_o,
  input wire logic [INT_W-1:0] int_pin_oe_o, int_pin_pu_o,
  input wire logic sck_pin_oe_o, mosi_pin_oe_o, miso_pin_oe_o
);
  // ==========================================================
  // sequences
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_req_low;
    (!stop_mode_i && !ext_reset_req_n_i) [*3];
  endsequence
  sequence s_bus_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // ==========================================================
  // properties
  int_rst_wins_a: assert property (
    int_sys_rst_i |=> !reset_out_pin_o) else $error("reset-out high after internal reset");
  rise_clean_a: assert property (
    $rose(reset_out_pin_o) |-> !$past(int_sys_rst_i)) else $error("reset-out rose during reset");
  pll_float_a: assert property (
    reset_out_pin_oe_o == !pll_test_mode_i) else $error("reset-out enable wrong");
  override_ok_a: assert property (
    data_bus_override_ok_o == !reset_out_pin_o) else $error("override flag wrong");
  scan_dirs_a: assert property (
    {reset_out_pin_ie_o, system_clock_out_ie_o, out_enable_pin_ie_o,
     reset_in_pin_oe_o} == {4{bscan_active_i}}) else $error("scan-only direction open");
  pullup_off_a: assert property (
    (int_pin_pu_o & int_pin_oe_o) == '0) else $error("pull-up on an output");
  spi_dirs_a: assert property (
    sck_pin_oe_o == mosi_pin_oe_o && miso_pin_oe_o == !sck_pin_oe_o) else $error("spi directions");
  raw_in_stop_a: assert property (
    stop_mode_i |-> ext_reset_req_n_o == ext_reset_req_n_i) else $error("stop mode not raw");
  sync_req_a: assert property (
    s_req_low |-> !ext_reset_req_n_o) else $error("synced request late");
  bus_ack_a: assert property (
    s_bus_req |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not one-cycle pulse");
  idle_data_a: assert property (
    !wb_ack_o |-> wb_dat_o == '0) else $error("read data outside ack");
endmodule // rpm_pin_mux_assertions

bind rpm_pin_mux rpm_pin_mux_assertions #(.INT_W(INT_W), .EMI_W(EMI_W)) u_chk (
  .clk_i, .sys_rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_dat_o, .int_sys_rst_i,
  .reset_out_pin_o, .reset_out_pin_oe_o, .pll_test_mode_i, .data_bus_override_ok_o,
  .bscan_active_i, .reset_out_pin_ie_o, .system_clock_out_ie_o,
  .out_enable_pin_ie_o, .reset_in_pin_oe_o, .stop_mode_i, .ext_reset_req_n_i,
  .ext_reset_req_n_o, .int_pin_oe_o, .int_pin_pu_o, .sck_pin_oe_o,
  .mosi_pin_oe_o, .miso_pin_oe_o);

// ==== bench/tb_top.sv ====
// self-checking bench for the reset-out and pin function mux.
// assumes the register map of rpm_regs.vh and the board model rpm_board.
`timescale 1ns/1ps
`include "rpm_regs.vh"
module tb_top;
  // ==========================================================
  // signals
  logic clk_i, sys_rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic int_sys_rst_i, irq_pending_i, pll_test_mode_i, stop_mode_i;
  logic emulation_mode_i, bscan_active_i, reset_out_pin_o, reset_out_pin_oe_o;
  logic reset_out_pin_ie_o, data_bus_override_ok_o, ext_reset_req_n_i;
  logic bscan_reset_pin_out_i, ext_reset_req_n_o, reset_in_pin_o;
  logic reset_in_pin_oe_o, system_clock_out_ie_o, out_enable_pin_ie_o;
  logic spi_sck_i, spi_mosi_i, spi_miso_i, sck_pin_o, sck_pin_oe_o, mosi_pin_o;
  logic mosi_pin_oe_o, miso_pin_o, miso_pin_oe_o, sck_pin_i, mosi_pin_i;
  logic miso_pin_i, spi_sck_in_o, spi_data_in_o, req_rst;
  logic [4:0]  wb_adr_i;
  logic [3:0]  wb_sel_i, cpu_processor_status_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [1:0]  cpu_transfer_size_i, sci_rxd_oe_i, sci_rxd_pu_o;
  logic [7:0]  int_pin_i, int_pin_o, int_pin_oe_o, int_pin_pu_o, eport_out_i;
  logic [7:0]  eport_oe_i, eport_in_o, eport_avail_o, emi_pin_i, emi_pin_o;
  logic [7:0]  emi_pin_oe_o, emi_func_out_i, emi_func_oe_i, emi_func_in_o;
  logic [7:0]  rnd = 8'h61, bg = 8'h61;
  int          error_cnt = 0, samples_checked = 0, i;

  rpm_pin_mux DUT (.clk_i, .sys_rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .int_sys_rst_i, .irq_pending_i,
    .pll_test_mode_i, .stop_mode_i, .emulation_mode_i, .bscan_active_i,
    .cpu_transfer_size_i, .cpu_processor_status_i, .reset_out_pin_o,
    .reset_out_pin_oe_o, .reset_out_pin_ie_o, .data_bus_override_ok_o,
    .ext_reset_req_n_i, .bscan_reset_pin_out_i, .ext_reset_req_n_o,
    .reset_in_pin_o, .reset_in_pin_oe_o, .system_clock_out_ie_o,
    .out_enable_pin_ie_o, .int_pin_i, .int_pin_o, .int_pin_oe_o, .int_pin_pu_o,
    .eport_out_i, .eport_oe_i, .eport_in_o, .eport_avail_o, .emi_pin_i,
    .emi_pin_o, .emi_pin_oe_o, .emi_func_out_i, .emi_func_oe_i, .emi_func_in_o,
    .sci_rxd_oe_i, .sci_rxd_pu_o, .spi_sck_i, .spi_mosi_i, .spi_miso_i,
    .sck_pin_o, .sck_pin_oe_o, .mosi_pin_o, .mosi_pin_oe_o, .miso_pin_o,
    .miso_pin_oe_o, .sck_pin_i, .mosi_pin_i, .miso_pin_i, .spi_sck_in_o,
    .spi_data_in_o);

  rpm_board u_board (.clk_i, .req_rst_i(req_rst), .int_drv_i(int_pin_o),
    .int_oe_i(int_pin_oe_o), .int_pu_i(int_pin_pu_o), .emi_drv_i(emi_pin_o),
    .emi_oe_i(emi_pin_oe_o), .rst_n_o(ext_reset_req_n_i),
    .int_line_o(int_pin_i), .emi_line_o(emi_pin_i));

  // ==========================================================
  // helpers
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic exp_ro(input logic irst, frc, show, irq);
    return irst ? 1'b0 : frc ? 1'b0 : show ? ~irq : 1'b1;
  endfunction
  task automatic chk(input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb_acc(input logic we, input logic [4:0] a,
                        input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= we;
    wb_adr_i <= a; wb_dat_i <= d; wb_sel_i <= 4'hF;
    do begin @(posedge clk_i); n++; end while (wb_ack_o !== 1'b1 && n < 20);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0;
    if (n >= 20) chk(32'h0000_0000, 32'h0000_0001);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ==========================================================
  // clock, background traffic, watchdog
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    bg <= lfsr(bg);
    {eport_out_i, eport_oe_i, emi_func_out_i, emi_func_oe_i} <= {bg, ~bg, ~bg, bg};
    {sci_rxd_oe_i, sck_pin_i, mosi_pin_i, miso_pin_i, spi_sck_i, spi_mosi_i,
     spi_miso_i, bscan_reset_pin_out_i} <= {bg, bg[3]};
  end
  initial begin
    #200_000;
    error_cnt++;
    tally_and_finish();
  end

  // ==========================================================
  // scenarios
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, int_sys_rst_i, irq_pending_i, req_rst} = '0;
    {pll_test_mode_i, stop_mode_i, emulation_mode_i, bscan_active_i} = '0;
    {wb_adr_i, wb_sel_i, wb_dat_i, cpu_transfer_size_i, cpu_processor_status_i} = '0;
    {eport_out_i, eport_oe_i, emi_func_out_i, emi_func_oe_i, sci_rxd_oe_i} = '0;
    {sck_pin_i, mosi_pin_i, miso_pin_i, spi_sck_i, spi_mosi_i, spi_miso_i} = '0;
    bscan_reset_pin_out_i = 1'b0;
    sys_rst_i = 1'b1;
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    @(negedge clk_i);
    chk(reset_out_pin_o, 1'b1);
    chk(sci_rxd_pu_o, 2'b00);
    wb_acc(1'b0, `RPM_OFF_CHIP_CFG, 32'h0000_0000, q);
    chk(q, `RPM_CHIP_CFG_RV);
    wb_acc(1'b0, 5'h18, 32'h0000_0000, q);
    chk(q, 32'h0000_0000);
    // every combination of the reset-out priority chain, irq randomised
    for (i = 0; i < 8; i++) begin
      int_sys_rst_i <= 1'b0;
      wb_acc(1'b1, `RPM_OFF_RST_CTRL, {31'h0, i[1]}, q);
      wb_acc(1'b1, `RPM_OFF_CHIP_CFG, {31'h0, i[2]}, q);
      repeat (6) begin
        rnd = lfsr(rnd);
        @(posedge clk_i);
        int_sys_rst_i <= i[0];
        irq_pending_i <= rnd[0];
        @(posedge clk_i);
        @(negedge clk_i);
        q = exp_ro(i[0], i[1], i[2], rnd[0]);
        chk(reset_out_pin_o, q);
        chk(data_bus_override_ok_o, !q[0]);
      end
    end
    int_sys_rst_i <= 1'b0;
    wb_acc(1'b1, `RPM_OFF_RST_CTRL, 32'h0000_0000, q);
    // status mirroring on int pins, with serial pull-ups enabled
    wb_acc(1'b1, `RPM_OFF_CHIP_CFG, 32'h0000_001E, q);
    repeat (8) begin
      rnd = lfsr(rnd);
      @(posedge clk_i);
      {cpu_transfer_size_i, cpu_processor_status_i} <= rnd[5:0];
      pll_test_mode_i <= rnd[6];
      bscan_active_i  <= rnd[7];
      @(negedge clk_i);
      chk(int_pin_o[7:2], rnd[5:0]);
      chk(int_pin_oe_o[7:2], 6'h3F);
      chk(eport_avail_o[7:2], 6'h00);
      chk(reset_out_pin_oe_o, !rnd[6]);
      chk({reset_out_pin_ie_o, reset_in_pin_oe_o}, {2{rnd[7]}});
      chk(reset_in_pin_o, bscan_reset_pin_out_i);
      chk(sci_rxd_pu_o, {~sci_rxd_oe_i});
    end
    // int pins as gpio: low nibble driven, high nibble pulled up
    wb_acc(1'b1, `RPM_OFF_CHIP_CFG, 32'h0000_0040, q);
    wb_acc(1'b1, `RPM_OFF_INT_GPIO, 32'h00FF_0FA5, q);
    wb_acc(1'b1, `RPM_OFF_INT_PAD, 32'h0000_00FF, q);
    @(negedge clk_i);
    chk({int_pin_oe_o, int_pin_pu_o, int_pin_o[3:0]}, 20'h0F_F05);
    wb_acc(1'b1, `RPM_OFF_INT_PAD, 32'h0000_0FFF, q);
    @(negedge clk_i);
    chk({int_pin_oe_o, int_pin_pu_o}, 16'h0AF5);
    wb_acc(1'b1, `RPM_OFF_EMI_GPIO, 32'h0000_F03C, q);
    @(negedge clk_i);
    chk({emi_pin_oe_o, emi_pin_o[7:4]}, 12'hF03);
    wb_acc(1'b0, `RPM_OFF_STATUS, 32'h0000_0000, q);
    chk(q[7:0], 8'hF5);
    // spi slave then master
    for (i = 0; i < 2; i++) begin
      wb_acc(1'b1, `RPM_OFF_CHIP_CFG, {26'h0, i[0], 5'h0}, q);
      @(negedge clk_i);
      q = {i[0], i[0], ~i[0]};
      chk({sck_pin_oe_o, mosi_pin_oe_o, miso_pin_oe_o}, q);
      chk(spi_data_in_o, i[0] ? miso_pin_i : mosi_pin_i);
    end
    // raw request in stop mode, then two-stage synchroniser lag
    @(posedge clk_i);
    stop_mode_i <= 1'b1;
    req_rst     <= 1'b1;
    @(negedge clk_i);
    chk(ext_reset_req_n_o, 1'b0);
    @(posedge clk_i);
    stop_mode_i <= 1'b0;
    req_rst     <= 1'b0;
    for (i = 0; i < 3; i++) begin
      @(negedge clk_i);
      chk(ext_reset_req_n_o, i != 1);
      @(posedge clk_i);
    end
    // a held request outside stop mode comes through the synchroniser
    req_rst <= 1'b1;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    chk(ext_reset_req_n_o, 1'b0);
    tally_and_finish();
  end
endmodule // tb_top
